/* design/lsr_pkg.sv */
// Types shared by the light sensor readout block.
package lsr_pkg;
  typedef logic [7:0]  lsr_byte_t;
  typedef logic [15:0] lsr_word_t;
  typedef logic [7:0]  lsr_addr_t;
endpackage

/* design/lsr_readout.sv */
// Read-side register file of a two-channel integrating light sensor.
// ==========================================================================
`timescale 1ns/1ps
`default_nettype none
`include "lsr_regs.svh"
module lsr_readout #(
  parameter logic [1:0] PACKAGE_CODE = 2'b11,      // Arbitrary value.
  parameter logic [7:0] PART_CODE    = 8'hA5       // Arbitrary value.
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Register access from the serial interface logic
  input  wire logic              rd_stb,
  input  wire logic              wr_stb,
  input  wire lsr_pkg::lsr_addr_t reg_addr,
  input  wire lsr_pkg::lsr_byte_t wr_data,
  output logic                   rd_valid,
  output lsr_pkg::lsr_byte_t     rd_data,
  // Converter side
  input  wire logic              converter_enable,
  input  wire logic              integ_done,
  input  wire lsr_pkg::lsr_word_t ch0_result,
  input  wire lsr_pkg::lsr_word_t ch1_result,
  input  wire logic              nopersist_hit,
  input  wire logic              threshold_irq_set,
  input  wire logic              nopersist_clr,
  input  wire logic              threshold_clr,
  // Interrupt enables and pin
  input  wire logic              threshold_irq_enable,
  input  wire logic              nopersist_irq_enable,
  output logic                   irq_out
);
  import lsr_pkg::*;

  // ========================================================================
  // Result registers and flags
  lsr_word_t ch0_q;
  lsr_word_t ch1_q;
  lsr_byte_t shadow0_q;
  lsr_byte_t shadow1_q;
  logic      nopersist_irq_flag_q;
  logic      threshold_irq_flag_q;
  logic      conversion_valid_flag_q;

  function automatic logic hit(input lsr_addr_t a, input lsr_addr_t target);
    hit = (a == target);
  endfunction

  logic rd_ch0_low;
  logic rd_ch1_low;
  assign rd_ch0_low = rd_stb && hit(reg_addr, `LSR_ADDR_CH0_LOW);
  assign rd_ch1_low = rd_stb && hit(reg_addr, `LSR_ADDR_CH1_LOW);

  // Both channels integrate together, so one completion strobe updates both.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ch0_q <= `LSR_RES_ZERO;
      ch1_q <= `LSR_RES_ZERO;
    end else if (integ_done) begin
      ch0_q <= ch0_result;
      ch1_q <= ch1_result;
    end
  end

  // The shadow takes the registered high byte, so a result landing in the same
  // cycle as the low read is not mixed in: low and shadow come from ch_q.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shadow0_q <= `LSR_BYTE_ZERO;
      shadow1_q <= `LSR_BYTE_ZERO;
    end else begin
      if (rd_ch0_low) begin
        shadow0_q <= ch0_q[`LSR_HI_MSB:`LSR_HI_LSB];
      end
      if (rd_ch1_low) begin
        shadow1_q <= ch1_q[`LSR_HI_MSB:`LSR_HI_LSB];
      end
    end
  end

  // Set wins over clear; host writes never reach these flags.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      nopersist_irq_flag_q <= 1'b0;
      threshold_irq_flag_q <= 1'b0;
    end else begin
      if (nopersist_hit && integ_done) begin
        nopersist_irq_flag_q <= 1'b1;
      end else if (nopersist_clr) begin
        nopersist_irq_flag_q <= 1'b0;
      end
      if (threshold_irq_set) begin
        threshold_irq_flag_q <= 1'b1;
      end else if (threshold_clr) begin
        threshold_irq_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      conversion_valid_flag_q <= 1'b0;
    end else if (!converter_enable) begin
      conversion_valid_flag_q <= 1'b0;
    end else if (integ_done) begin
      conversion_valid_flag_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= (threshold_irq_flag_q && threshold_irq_enable) ||
                 (nopersist_irq_flag_q && nopersist_irq_enable);
    end
  end

  // ========================================================================
  // Read mux
  lsr_byte_t status_byte;
  lsr_byte_t pkg_byte;
  lsr_byte_t rd_mux;
  always_comb begin
    status_byte = `LSR_BYTE_ZERO;
    status_byte[`LSR_ST_NOPERSIST] = nopersist_irq_flag_q;
    status_byte[`LSR_ST_THRESHOLD] = threshold_irq_flag_q;
    status_byte[`LSR_ST_VALID]     = conversion_valid_flag_q;
    pkg_byte = `LSR_BYTE_ZERO;
    pkg_byte[`LSR_PKG_MSB:`LSR_PKG_LSB] = PACKAGE_CODE;
    case (reg_addr)
      `LSR_ADDR_PACKAGE_CODE: rd_mux = pkg_byte;
      `LSR_ADDR_PART_CODE:    rd_mux = PART_CODE;
      `LSR_ADDR_STATUS:       rd_mux = status_byte;
      `LSR_ADDR_CH0_LOW:      rd_mux = ch0_q[`LSR_LO_MSB:`LSR_LO_LSB];
      `LSR_ADDR_CH0_HIGH:     rd_mux = shadow0_q;
      `LSR_ADDR_CH1_LOW:      rd_mux = ch1_q[`LSR_LO_MSB:`LSR_LO_LSB];
      `LSR_ADDR_CH1_HIGH:     rd_mux = shadow1_q;
      default:                rd_mux = `LSR_BYTE_ZERO;
    endcase
  end

  // Writes are accepted and dropped: every register here is read-only.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_valid <= 1'b0;
      rd_data  <= `LSR_BYTE_ZERO;
    end else begin
      rd_valid <= rd_stb;
      if (rd_stb) begin
        rd_data <= rd_mux;
      end
    end
  end

  // ========================================================================
  // Assertions
  property p_pkg_read;
    @(posedge clk_sys) disable iff (rst)
      rd_stb && reg_addr == `LSR_ADDR_PACKAGE_CODE |=> rd_valid && rd_data == {2'b00, PACKAGE_CODE, 4'h0};
  endproperty
  a_pkg_read: assert property (p_pkg_read) else $error("package code read wrong");

  property p_part_read;
    @(posedge clk_sys) disable iff (rst)
      rd_stb && reg_addr == `LSR_ADDR_PART_CODE |=> rd_data == PART_CODE;
  endproperty
  a_part_read: assert property (p_part_read) else $error("part code read wrong");

  property p_status_wr;
    @(posedge clk_sys) disable iff (rst)
      wr_stb && !nopersist_hit && !threshold_irq_set && !nopersist_clr && !threshold_clr
      |=> $stable(nopersist_irq_flag_q) && $stable(threshold_irq_flag_q);
  endproperty
  a_status_wr: assert property (p_status_wr) else $error("write disturbed status");

  property p_np_set;
    @(posedge clk_sys) disable iff (rst)
      nopersist_hit && integ_done |=> nopersist_irq_flag_q;
  endproperty
  a_np_set: assert property (p_np_set) else $error("no-persist flag not set");

  property p_np_imm;
    @(posedge clk_sys) disable iff (rst)
      nopersist_hit && integ_done && nopersist_irq_enable ##1 nopersist_irq_enable |=> irq_out;
  endproperty
  a_np_imm: assert property (p_np_imm) else $error("no-persist irq late");

  property p_thr_set;
    @(posedge clk_sys) disable iff (rst)
      threshold_irq_set |=> threshold_irq_flag_q;
  endproperty
  a_thr_set: assert property (p_thr_set) else $error("threshold flag not set");

  property p_valid;
    @(posedge clk_sys) disable iff (rst)
      converter_enable && integ_done ##1 converter_enable |=> conversion_valid_flag_q;
  endproperty
  a_valid: assert property (p_valid) else $error("valid flag missing");

  property p_shadow;
    @(posedge clk_sys) disable iff (rst)
      rd_ch0_low ##1 (rd_stb && reg_addr == `LSR_ADDR_CH0_HIGH)
      |=> rd_data == $past(ch0_q[`LSR_HI_MSB:`LSR_HI_LSB], 2);
  endproperty
  a_shadow: assert property (p_shadow) else $error("ch0 high byte not shadowed");

  property p_shadow1_own;
    @(posedge clk_sys) disable iff (rst)
      !rd_ch1_low |=> $stable(shadow1_q);
  endproperty
  a_shadow1_own: assert property (p_shadow1_own) else $error("ch1 shadow moved");

  property p_irq_gate;
    @(posedge clk_sys) disable iff (rst)
      !threshold_irq_enable && !nopersist_irq_enable |=> !irq_out;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq pin without enable");

  property p_status_rd;
    @(posedge clk_sys) disable iff (rst)
      rd_stb && reg_addr == `LSR_ADDR_STATUS |=> rd_data == {2'b00, $past(nopersist_irq_flag_q),
        $past(threshold_irq_flag_q), 3'b000, $past(conversion_valid_flag_q)};
  endproperty
  a_status_rd: assert property (p_status_rd) else $error("status read wrong");

  // Flags move only on their own set or clear, so host traffic can never touch them.
  property p_np_hold;
    @(posedge clk_sys) disable iff (rst)
      !(nopersist_hit && integ_done) && !nopersist_clr |=> $stable(nopersist_irq_flag_q);
  endproperty
  a_np_hold: assert property (p_np_hold) else $error("no-persist flag moved without cause");

  property p_thr_hold;
    @(posedge clk_sys) disable iff (rst)
      !threshold_irq_set && !threshold_clr |=> $stable(threshold_irq_flag_q);
  endproperty
  a_thr_hold: assert property (p_thr_hold) else $error("threshold flag moved without cause");

  property p_valid_clr;
    @(posedge clk_sys) disable iff (rst)
      !converter_enable |=> !conversion_valid_flag_q;
  endproperty
  a_valid_clr: assert property (p_valid_clr) else $error("valid flag set while disabled");

  property p_ch0_low;
    @(posedge clk_sys) disable iff (rst)
      rd_ch0_low |=> rd_valid && rd_data == $past(ch0_q[`LSR_LO_MSB:`LSR_LO_LSB]);
  endproperty
  a_ch0_low: assert property (p_ch0_low) else $error("ch0 low byte read wrong");

  property p_ch1_low;
    @(posedge clk_sys) disable iff (rst)
      rd_ch1_low |=> rd_valid && rd_data == $past(ch1_q[`LSR_LO_MSB:`LSR_LO_LSB]);
  endproperty
  a_ch1_low: assert property (p_ch1_low) else $error("ch1 low byte read wrong");

  property p_shadow1;
    @(posedge clk_sys) disable iff (rst)
      rd_ch1_low ##1 (rd_stb && reg_addr == `LSR_ADDR_CH1_HIGH)
      |=> rd_data == $past(ch1_q[`LSR_HI_MSB:`LSR_HI_LSB], 2);
  endproperty
  a_shadow1: assert property (p_shadow1) else $error("ch1 high byte not shadowed");

  property p_shadow0_own;
    @(posedge clk_sys) disable iff (rst)
      !rd_ch0_low |=> $stable(shadow0_q);
  endproperty
  a_shadow0_own: assert property (p_shadow0_own) else $error("ch0 shadow moved");

  property p_thr_pin;
    @(posedge clk_sys) disable iff (rst)
      threshold_irq_flag_q && threshold_irq_enable |=> irq_out;
  endproperty
  a_thr_pin: assert property (p_thr_pin) else $error("threshold irq missing on pin");

  property p_rd_ack;
    @(posedge clk_sys) disable iff (rst)
      rd_stb |=> rd_valid;
  endproperty
  a_rd_ack: assert property (p_rd_ack) else $error("read not answered");

  property p_rd_idle;
    @(posedge clk_sys) disable iff (rst)
      !rd_stb |=> !rd_valid && $stable(rd_data);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data moved without a read");

  c_np: cover property (@(posedge clk_sys) disable iff (rst) nopersist_hit && integ_done ##2 irq_out);
  c_shadow: cover property (@(posedge clk_sys) disable iff (rst)
    rd_ch0_low ##[1:4] integ_done ##[1:4] rd_stb && reg_addr == `LSR_ADDR_CH0_HIGH);
  c_valid: cover property (@(posedge clk_sys) disable iff (rst) $rose(conversion_valid_flag_q));
  c_burst: cover property (@(posedge clk_sys) disable iff (rst) rd_ch0_low ##1 rd_stb ##1 rd_ch1_low ##1 rd_stb);
endmodule
`default_nettype wire

/* design/lsr_regs.svh */
// Register offsets, field positions and zero constants of the light sensor readout block.
`ifndef LSR_REGS_SVH
`define LSR_REGS_SVH
`define LSR_ADDR_PACKAGE_CODE 8'h11
`define LSR_ADDR_PART_CODE    8'h12
`define LSR_ADDR_STATUS       8'h13
`define LSR_ADDR_CH0_LOW      8'h14
`define LSR_ADDR_CH0_HIGH     8'h15
`define LSR_ADDR_CH1_LOW      8'h16
`define LSR_ADDR_CH1_HIGH     8'h17
`define LSR_PKG_LSB           4
`define LSR_PKG_MSB           5
`define LSR_ST_NOPERSIST      5
`define LSR_ST_THRESHOLD      4
`define LSR_ST_VALID          0
`define LSR_BYTE_ZERO         8'h00
`define LSR_RES_ZERO          16'h0000
`define LSR_HI_MSB            15
`define LSR_HI_LSB            8
`define LSR_LO_MSB            7
`define LSR_LO_LSB            0
`endif

/* test/lsr_host_model.sv */
// Host-side model that issues byte reads and writes to the readout register block.
`timescale 1ns/1ps
`default_nettype none
`include "lsr_regs.svh"
module lsr_host_model (
  // Clock
  input  wire logic               clk_sys,
  // Register access
  output var  logic               rd_stb,
  output var  logic               wr_stb,
  output var  lsr_pkg::lsr_addr_t reg_addr,
  output var  lsr_pkg::lsr_byte_t wr_data,
  input  wire logic               rd_valid,
  input  wire lsr_pkg::lsr_byte_t rd_data
);
  import lsr_pkg::*;
  initial begin
    rd_stb   = 1'b0;
    wr_stb   = 1'b0;
    reg_addr = 8'h00;
    wr_data  = 8'h00;
  end
  // Released lines show the inverse of the last value, so a design that samples late is caught.
  task automatic rd_byte(input lsr_addr_t a, output lsr_byte_t d, output bit ok);
    int i;
    ok = 1'b0;
    d  = 8'h00;
    @(posedge clk_sys);
    rd_stb   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    rd_stb   <= 1'b0;
    reg_addr <= ~a;
    for (i = 0; i < 4; i++) begin
      #1;
      if (rd_valid === 1'b1) begin
        d  = rd_data;
        ok = 1'b1;
        break;
      end
      @(posedge clk_sys);
    end
  endtask
  task automatic wr_byte(input lsr_addr_t a, input lsr_byte_t v);
    @(posedge clk_sys);
    wr_stb   <= 1'b1;
    reg_addr <= a;
    wr_data  <= v;
    @(posedge clk_sys);
    wr_stb   <= 1'b0;
    reg_addr <= ~a;
    wr_data  <= ~v;
  endtask
  // Reads all four result bytes back to back in address order to limit channel skew.
  // The strobe stays high for four edges; each answer is taken one cycle after its address.
  task automatic rd_results(output lsr_byte_t r [4], output bit ok);
    ok = 1'b1;
    @(posedge clk_sys);
    rd_stb   <= 1'b1;
    reg_addr <= `LSR_ADDR_CH0_LOW;
    for (int j = 0; j < 4; j++) begin
      @(posedge clk_sys);
      if (j < 3) begin
        reg_addr <= `LSR_ADDR_CH0_LOW + j[7:0] + 8'h01;
      end else begin
        rd_stb   <= 1'b0;
        reg_addr <= ~`LSR_ADDR_CH1_HIGH;
      end
      #1;
      r[j] = rd_data;
      if (rd_valid !== 1'b1) begin
        ok = 1'b0;
      end
    end
  endtask
endmodule
`default_nettype wire

/* test/test_light_sensor_readout_regs.sv */
// Self-checking testbench of the light sensor readout register block.
`timescale 1ns/1ps
`default_nettype none
`include "lsr_regs.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_errors++; \
  $display("Error t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_light_sensor_readout_regs;
  import lsr_pkg::*;
  localparam logic [1:0] PKG = 2'b10;  // Arbitrary value.
  localparam logic [7:0] PRT = 8'h3C;  // Arbitrary value.
  logic clk_sys = 1'b0, rst = 1'b1, rd_stb, wr_stb, rd_valid, irq_out;
  logic converter_enable = 1'b0, integ_done = 1'b0, nopersist_hit = 1'b0, threshold_irq_set = 1'b0;
  logic nopersist_clr = 1'b0, threshold_clr = 1'b0, threshold_irq_enable = 1'b0, nopersist_irq_enable = 1'b0;
  lsr_addr_t reg_addr;
  lsr_byte_t wr_data, rd_data, d, r [4];
  lsr_word_t ch0_result = 16'h0000, ch1_result = 16'h0000;
  int n_errors = 0, check_count = 0;
  bit ok;
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  lsr_readout #(.PACKAGE_CODE(PKG), .PART_CODE(PRT)) uut (.clk_sys(clk_sys), .rst(rst), .rd_stb(rd_stb),
    .wr_stb(wr_stb), .reg_addr(reg_addr), .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data),
    .converter_enable(converter_enable), .integ_done(integ_done), .ch0_result(ch0_result),
    .ch1_result(ch1_result), .nopersist_hit(nopersist_hit), .threshold_irq_set(threshold_irq_set),
    .nopersist_clr(nopersist_clr), .threshold_clr(threshold_clr),
    .threshold_irq_enable(threshold_irq_enable), .nopersist_irq_enable(nopersist_irq_enable), .irq_out(irq_out));
  lsr_host_model host (.clk_sys(clk_sys), .rd_stb(rd_stb), .wr_stb(wr_stb), .reg_addr(reg_addr),
    .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data));
  task automatic summarize();
    $display("Counts: %0d checks, %0d mismatches", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // A read that never answers counts as a mismatch and ends the run.
  task automatic rd_chk(input lsr_addr_t a, input lsr_byte_t exp);
    host.rd_byte(a, d, ok);
    if (!ok) begin
      n_errors++;
      summarize();
    end
    `CHK(d, exp)
  endtask
  task automatic integ(input lsr_word_t c0, input lsr_word_t c1, input logic np);
    @(posedge clk_sys);
    integ_done    <= 1'b1;
    ch0_result    <= c0;
    ch1_result    <= c1;
    nopersist_hit <= np;
    @(posedge clk_sys);
    integ_done    <= 1'b0;
    nopersist_hit <= 1'b0;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    rd_chk(`LSR_ADDR_PACKAGE_CODE, {2'b00, PKG, 4'h0});
    rd_chk(`LSR_ADDR_PART_CODE, PRT);
    rd_chk(8'h20, 8'h00);
    host.wr_byte(`LSR_ADDR_STATUS, 8'hFF);
    host.wr_byte(`LSR_ADDR_PART_CODE, 8'h00);
    rd_chk(`LSR_ADDR_STATUS, 8'h00);
    rd_chk(`LSR_ADDR_PART_CODE, PRT);
    $display("Test identification and write refusal done");
    @(posedge clk_sys);
    converter_enable <= 1'b1;
    integ(16'h1234, 16'hABCD, 1'b0);
    rd_chk(`LSR_ADDR_STATUS, 8'h01);
    rd_chk(`LSR_ADDR_CH1_HIGH, 8'h00);
    rd_chk(`LSR_ADDR_CH0_LOW, 8'h34);
    integ(16'h5678, 16'h9ABC, 1'b0);
    rd_chk(`LSR_ADDR_CH0_HIGH, 8'h12);
    rd_chk(`LSR_ADDR_CH0_HIGH, 8'h12);
    host.rd_results(r, ok);
    if (!ok) begin
      n_errors++;
      summarize();
    end
    `CHK({r[1], r[0], r[3], r[2]}, 32'h5678_9ABC)
    $display("Test result shadows done");
    integ(16'h0001, 16'h0002, 1'b1);
    host.wr_byte(`LSR_ADDR_STATUS, 8'h00);
    rd_chk(`LSR_ADDR_STATUS, 8'h21);
    `CHK(irq_out, 1'b0)
    @(posedge clk_sys);
    nopersist_irq_enable <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK(irq_out, 1'b1)
    @(posedge clk_sys);
    threshold_irq_set <= 1'b1;
    nopersist_clr     <= 1'b1;
    @(posedge clk_sys);
    threshold_irq_set <= 1'b0;
    nopersist_clr     <= 1'b0;
    rd_chk(`LSR_ADDR_STATUS, 8'h11);
    `CHK(irq_out, 1'b0)
    @(posedge clk_sys);
    threshold_irq_enable <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK(irq_out, 1'b1)
    @(posedge clk_sys);
    threshold_clr    <= 1'b1;
    converter_enable <= 1'b0;
    @(posedge clk_sys);
    threshold_clr <= 1'b0;
    rd_chk(`LSR_ADDR_STATUS, 8'h00);
    integ(16'h0003, 16'h0004, 1'b1);
    @(posedge clk_sys);
    #1;
    `CHK(irq_out, 1'b1)
    $display("Test status flags and interrupt pin done");
    summarize();
  end
endmodule
`default_nettype wire
